// ===== shared/gdp_pkg.sv
// constants, types and enumerations for the gated delayed pulse generator
// assumes a single 25 MHz system clock; all pins synchronous to it
`default_nettype none
package gdp_pkg;
    localparam int unsigned CNT_W         = 32;
    localparam int unsigned DIV_W         = 8;
    // internal timebase = clock / (INT_DIV_LAST + 1)
    localparam logic [DIV_W-1:0] INT_DIV_LAST = 8'h04;
    localparam logic [DIV_W-1:0] DIV_RST      = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE      = 32'h0000_0001;
    localparam logic [CNT_W-1:0] MIN_INT_CYC  = 32'h0000_0003;
    // zero length on the external timebase still takes one cycle
    localparam logic [CNT_W-1:0] MIN_EXT_CYC  = 32'h0000_0001;

    typedef enum logic [0:0] {
        TB_INTERNAL = 1'b0,
        TB_EXTERNAL = 1'b1
    } gdp_tb_t;

    typedef enum logic [2:0] {
        GATE_NONE    = 3'b000,
        GATE_HIGH    = 3'b001,
        GATE_LOW     = 3'b010,
        GATE_RISE    = 3'b011,
        GATE_FALL    = 3'b100
    } gdp_gate_t;

    typedef enum logic [0:0] {
        POL_HIGH_PULSE = 1'b0,
        POL_LOW_PULSE  = 1'b1
    } gdp_pol_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_DELAY = 2'b10,
        ST_WIDTH = 2'b11
    } gdp_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] delay_cycles;
        logic [CNT_W-1:0] width_cycles;
        gdp_tb_t          timebase;
        gdp_gate_t        gate_mode;
        gdp_pol_t         polarity;
    } gdp_cfg_t;

    typedef struct packed {
        logic busy;
        logic armed;
        logic in_width;
    } gdp_status_t;
endpackage : gdp_pkg
`default_nettype wire

// ===== hdl/gdp_pulse_gen.sv
// single delayed pulse generator with gate and selectable timebase
// cfg is sampled on start; start and stop are one-cycle pulses
// all pin inputs are taken as synchronous to clock
`timescale 1ns/1ns
`default_nettype none
module gdp_pulse_gen (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire gdp_pkg::gdp_cfg_t cfg,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic             gate_input_pin,
    input  wire logic             external_timebase_pin,
    output var  logic             pulse_output_pin,
    output var  gdp_pkg::gdp_status_t status
);
    import gdp_pkg::*;

    typedef struct packed {
        gdp_state_t       st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] width;
        gdp_tb_t          tb;
        gdp_gate_t        mode;
        gdp_pol_t         pol;
        logic [DIV_W-1:0] div;
        logic             gate_prev;
        logic             src_prev;
        logic             out;
        gdp_status_t      stat;
    } gdp_regs_t;

    gdp_regs_t q;
    gdp_regs_t d;

    logic             div_tick;
    logic             tick;
    logic             gate_ok;
    logic             gate_rise;
    logic             gate_fall;
    logic             advance;
    logic [CNT_W-1:0] eff_delay;
    logic [CNT_W-1:0] eff_width;

    always_comb begin
        div_tick  = (q.div == INT_DIV_LAST);
        // external timebase counts rising edges of its pin
        tick      = (q.tb == TB_EXTERNAL) ? (external_timebase_pin & ~q.src_prev)
                                          : div_tick;
        gate_rise = gate_input_pin & ~q.gate_prev;
        gate_fall = ~gate_input_pin & q.gate_prev;
        unique case (q.mode)
            GATE_HIGH: gate_ok = gate_input_pin;
            GATE_LOW:  gate_ok = ~gate_input_pin;
            default:   gate_ok = 1'b1;
        endcase
        advance   = tick & gate_ok;
        if (cfg.delay_cycles == CNT_ZERO) begin
            eff_delay = (cfg.timebase == TB_INTERNAL) ? MIN_INT_CYC : MIN_EXT_CYC;
        end else begin
            eff_delay = cfg.delay_cycles;
        end
        if (cfg.width_cycles == CNT_ZERO) begin
            eff_width = (cfg.timebase == TB_INTERNAL) ? MIN_INT_CYC : MIN_EXT_CYC;
        end else begin
            eff_width = cfg.width_cycles;
        end

        d           = q;
        d.gate_prev = gate_input_pin;
        d.src_prev  = external_timebase_pin;
        d.div       = div_tick ? DIV_RST : DIV_W'(q.div + 8'h01);

        unique case (q.st)
            ST_IDLE: begin
                if (start && !stop) begin
                    d.width = eff_width;
                    d.cnt   = eff_delay;
                    d.tb    = cfg.timebase;
                    d.mode  = cfg.gate_mode;
                    d.pol   = cfg.polarity;
                    d.div   = DIV_RST;
                    if (cfg.gate_mode == GATE_RISE || cfg.gate_mode == GATE_FALL) begin
                        d.st = ST_ARMED;
                    end else begin
                        d.st = ST_DELAY;
                    end
                end
            end
            ST_ARMED: begin
                // only the first qualifying edge launches the pulse
                if ((q.mode == GATE_RISE && gate_rise) ||
                    (q.mode == GATE_FALL && gate_fall)) begin
                    d.st = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (advance) begin
                    if (q.cnt == CNT_ONE) begin
                        d.st  = ST_WIDTH;
                        d.cnt = q.width;
                    end else begin
                        d.cnt = CNT_W'(q.cnt - CNT_ONE);
                    end
                end
            end
            ST_WIDTH: begin
                if (advance) begin
                    if (q.cnt == CNT_ONE) begin
                        d.st  = ST_IDLE;
                        d.cnt = CNT_ZERO;
                    end else begin
                        d.cnt = CNT_W'(q.cnt - CNT_ONE);
                    end
                end
            end
        endcase

        if (stop) begin
            d.st  = ST_IDLE;
            d.cnt = CNT_ZERO;
        end

        // level derives from the next phase so the pin is a flop
        d.out           = d.pol ^ (d.st == ST_WIDTH);
        d.stat.busy     = (d.st != ST_IDLE);
        d.stat.armed    = (d.st == ST_ARMED);
        d.stat.in_width = (d.st == ST_WIDTH);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: ST_IDLE, cnt: CNT_ZERO, width: CNT_ZERO, tb: TB_INTERNAL,
                   mode: GATE_NONE, pol: POL_HIGH_PULSE, div: DIV_RST,
                   gate_prev: 1'b0, src_prev: 1'b0, out: 1'b0,
                   stat: '{busy: 1'b0, armed: 1'b0, in_width: 1'b0}};
        end else begin
            q <= d;
        end
    end

    assign pulse_output_pin = q.out;
    assign status           = q.stat;

    sequence s_last_delay;
        (q.st == ST_DELAY) && advance && (q.cnt == CNT_ONE) && !stop;
    endsequence

    sequence s_width_entered;
        (q.st == ST_WIDTH) && (q.cnt == $past(q.width));
    endsequence

    property p_delay_to_width;
        @(posedge clock) disable iff (sys_rst)
        s_last_delay |=> s_width_entered;
    endproperty
    a_delay_to_width: assert property (p_delay_to_width)
        else $error("delay end did not enter width phase");

    property p_ext_tick;
        @(posedge clock) disable iff (sys_rst)
        (q.tb == TB_EXTERNAL) && (q.st == ST_DELAY) && !stop && !external_timebase_pin
        |=> (q.st == ST_DELAY) && (q.cnt == $past(q.cnt));
    endproperty
    a_ext_tick: assert property (p_ext_tick)
        else $error("counter moved without external timebase edge");

    property p_int_rate;
        @(posedge clock) disable iff (sys_rst)
        (q.tb == TB_INTERNAL) && (q.st == ST_DELAY) && (q.mode == GATE_NONE)
        && (q.cnt > MIN_INT_CYC) && (q.div == DIV_RST) && !stop
        ##1 !stop [*4] |=> (q.cnt == $past(q.cnt, 5) - CNT_ONE);
    endproperty
    a_int_rate: assert property (p_int_rate)
        else $error("internal timebase rate wrong");

    property p_min_delay;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_IDLE) && start && !stop && (cfg.timebase == TB_INTERNAL)
        && (cfg.delay_cycles == CNT_ZERO) |=> (q.cnt == MIN_INT_CYC);
    endproperty
    a_min_delay: assert property (p_min_delay)
        else $error("zero delay not raised to three cycles");

    property p_min_width;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_IDLE) && start && !stop && (cfg.timebase == TB_INTERNAL)
        && (cfg.width_cycles == CNT_ZERO) |=> (q.width == MIN_INT_CYC);
    endproperty
    a_min_width: assert property (p_min_width)
        else $error("zero width not raised to three cycles");

    property p_ungated_start;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_IDLE) && start && !stop && (cfg.gate_mode == GATE_NONE)
        |=> (q.st == ST_DELAY) && status.busy;
    endproperty
    a_ungated_start: assert property (p_ungated_start)
        else $error("ungated start did not begin delay");

    property p_gate_high;
        @(posedge clock) disable iff (sys_rst)
        (q.mode == GATE_HIGH) && (q.st inside {ST_DELAY, ST_WIDTH}) && !gate_input_pin
        && !stop |=> $stable(q.cnt) && $stable(q.st);
    endproperty
    a_gate_high: assert property (p_gate_high)
        else $error("counted while gate low in high-gate mode");

    property p_gate_low;
        @(posedge clock) disable iff (sys_rst)
        (q.mode == GATE_LOW) && (q.st inside {ST_DELAY, ST_WIDTH}) && gate_input_pin
        && !stop |=> $stable(q.cnt) && $stable(q.st);
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("counted while gate high in low-gate mode");

    property p_wait_rise;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_ARMED) && (q.mode == GATE_RISE) && !stop
        |=> (q.st == ST_DELAY) == $past(gate_rise);
    endproperty
    a_wait_rise: assert property (p_wait_rise)
        else $error("rising-edge trigger misbehaved");

    property p_wait_fall;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_ARMED) && (q.mode == GATE_FALL) && !stop
        |=> (q.st == ST_DELAY) == $past(gate_fall);
    endproperty
    a_wait_fall: assert property (p_wait_fall)
        else $error("falling-edge trigger misbehaved");

    property p_single_shot;
        @(posedge clock) disable iff (sys_rst)
        (q.st inside {ST_DELAY, ST_WIDTH}) |=> (q.st != ST_ARMED);
    endproperty
    a_single_shot: assert property (p_single_shot)
        else $error("trigger re-armed during pulse");

    property p_pol_levels;
        @(posedge clock) disable iff (sys_rst)
        (q.st != ST_IDLE) |-> (pulse_output_pin == (q.pol ^ (q.st == ST_WIDTH)));
    endproperty
    a_pol_levels: assert property (p_pol_levels)
        else $error("output level wrong for phase and polarity");

    property p_stop;
        @(posedge clock) disable iff (sys_rst)
        stop |=> (q.st == ST_IDLE) && !status.busy && (pulse_output_pin == q.pol);
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop did not halt counter");

    property p_return_idle;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_WIDTH) && advance && (q.cnt == CNT_ONE)
        |=> (q.st == ST_IDLE) && (pulse_output_pin == q.pol) ##1 (q.st == ST_IDLE) || $past(start);
    endproperty
    a_return_idle: assert property (p_return_idle)
        else $error("did not return to idle after pulse");

    property p_pol_latch;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_IDLE) && start && !stop
        |=> (pulse_output_pin == $past(cfg.polarity));
    endproperty
    a_pol_latch: assert property (p_pol_latch)
        else $error("delay level does not follow polarity setting");

    property p_busy_ignores_start;
        @(posedge clock) disable iff (sys_rst)
        (q.st != ST_IDLE) && start && !stop
        |=> (q.width == $past(q.width)) && (q.pol == $past(q.pol))
            && (q.mode == $past(q.mode));
    endproperty
    a_busy_ignores_start: assert property (p_busy_ignores_start)
        else $error("start while busy changed the running pulse");

    property p_int_hold;
        @(posedge clock) disable iff (sys_rst)
        (q.tb == TB_INTERNAL) && (q.st inside {ST_DELAY, ST_WIDTH})
        && !div_tick && !stop
        |=> $stable(q.cnt) && $stable(q.st);
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("counter moved between internal timebase ticks");

    property p_gate_none;
        @(posedge clock) disable iff (sys_rst)
        (q.mode == GATE_NONE) && (q.st == ST_DELAY) && tick
        && (q.cnt != CNT_ONE) && !stop
        |=> (q.cnt == $past(q.cnt) - CNT_ONE);
    endproperty
    a_gate_none: assert property (p_gate_none)
        else $error("ungated counter missed a timebase tick");

    property p_armed_hold;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_ARMED) && !stop
        |=> $stable(q.cnt) && (pulse_output_pin == q.pol);
    endproperty
    a_armed_hold: assert property (p_armed_hold)
        else $error("counter or output moved while waiting for gate edge");

    property p_idle_level;
        @(posedge clock) disable iff (sys_rst)
        (q.st == ST_IDLE)
        |-> (pulse_output_pin == q.pol) && !status.busy && (q.cnt == CNT_ZERO);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("idle output or status wrong");
endmodule : gdp_pulse_gen
`default_nettype wire

// ===== verif/gdp_far_end.sv
// far-side model: external timebase source for the pulse generator
// free running, toggled on the falling clock edge; half sets the pace
`timescale 1ns/1ns
`default_nettype none
module gdp_far_end (
    input  wire logic       clock,
    input  wire logic [1:0] half,
    output var  logic       tb_pin
);
    int   cnt = 0;
    logic lvl = 1'b0;

    assign tb_pin = lvl;

    // prompt at half 1, slow at half 3
    always @(negedge clock) begin
        cnt = cnt + 1;
        if (cnt >= int'(half)) begin
            cnt = 0;
            lvl <= ~lvl;
        end
    end
endmodule : gdp_far_end
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for gdp_pulse_gen
// inputs change on the falling edge; external timebase from gdp_far_end
`timescale 1ns/1ns
`default_nettype none
module tb;
    import gdp_pkg::*;
    logic        clock, sys_rst, start, stop, gate_input_pin;
    logic        gate_rand, gate_lvl, lpol, ext_prev, pulse_output_pin;
    logic [1:0]  half;
    gdp_cfg_t    cfg;
    gdp_status_t status;
    wire logic   ext_pin;
    int          num_errors = 0;
    int          n_tests = 0;
    int          seed = 28;
    int          dcnt, wcnt, i;

    gdp_pulse_gen gdp_pulse_gen_i (.clock(clock), .sys_rst(sys_rst), .cfg(cfg),
        .start(start), .stop(stop), .gate_input_pin(gate_input_pin),
        .external_timebase_pin(ext_pin), .pulse_output_pin(pulse_output_pin),
        .status(status));
    gdp_far_end gdp_far_end_i (.clock(clock), .half(half), .tb_pin(ext_pin));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(negedge clock) gate_input_pin <= gate_rand ? 1'($random(seed)) : gate_lvl;

    // reference: count clock cycles (internal) or timebase edges (external) per phase, check level every cycle
    always @(posedge clock) begin
        if (sys_rst) begin
            lpol = 1'b0;
        end else begin
            check(pulse_output_pin, lpol ^ status.in_width);
            if (status.busy && !status.armed && (cfg.timebase == TB_INTERNAL ||
                (ext_pin && !ext_prev && (cfg.gate_mode != GATE_HIGH || gate_input_pin)
                 && (cfg.gate_mode != GATE_LOW || !gate_input_pin)))) begin
                if (status.in_width) wcnt++;
                else dcnt++;
            end
            if (start && !stop && !status.busy) begin
                lpol = cfg.polarity;
                dcnt = 0;
                wcnt = 0;
            end
        end
        ext_prev = ext_pin;
    end

    task automatic run(input int d, w, ext, gm, pol, stopat);
        int ed, ew;
        ed = (d == 0) ? (ext != 0 ? 1 : 3) : d;
        ew = (w == 0) ? (ext != 0 ? 1 : 3) : w;
        if (ext == 0) begin
            ed = ed * 5;
            ew = ew * 5;
        end
        @(negedge clock);
        gate_rand = (gm == 1 || gm == 2);
        gate_lvl = (gm == 4);
        cfg = '{32'(d), 32'(w), gdp_tb_t'(ext[0]), gdp_gate_t'(gm[2:0]), gdp_pol_t'(pol[0])};
        repeat (3) @(negedge clock);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        cfg.delay_cycles = 32'h0000_0009;
        if (gm >= 3) begin
            repeat (10) @(negedge clock);
            check(status.armed, 1);
            gate_rand = 1'b1;
        end
        // second start while busy must be ignored
        for (i = 0; i < 3000 && status.busy; i++) begin
            @(negedge clock);
            stop = (i == stopat) && status.busy;
            start = (i == 2) && status.busy;
        end
        if (i >= 3000) begin
            num_errors++;
            report_and_stop();
        end
        if (stopat < 3000) check(i, stopat + 2);
        else begin
            check(dcnt, ed);
            check(wcnt, ew);
        end
        gate_rand = 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clock);
            check(status.busy, 0);
        end
        $display("test done: mode %0d ext %0d stop %0d", gm, ext, stopat);
    endtask : run

    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        stop = 1'b0;
        gate_rand = 1'b0;
        gate_lvl = 1'b0;
        half = 2'h1;
        cfg = '0;
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        run(2, 1, 0, 0, 0, 5000);
        run(0, 0, 0, 0, 1, 5000);
        run(5, 5, 0, 0, 0, 8);
        run(2, 5, 0, 0, 1, 14);
        for (int k = 0; k < 15; k++) begin
            half = 2'({$random(seed)} % 3 + 1);
            run({$random(seed)} % 6, {$random(seed)} % 6, 1, k % 5, {$random(seed)} % 2, 5000);
        end
        // reset in mid-delay drops the high delay level
        cfg = '{32'h0000_0004, 32'h0000_0004, TB_INTERNAL, GATE_NONE, POL_LOW_PULSE};
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        repeat (4) @(negedge clock);
        check(pulse_output_pin, 1'b1);
        sys_rst = 1'b1;
        @(negedge clock);
        check({pulse_output_pin, status}, 4'h0);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        check({pulse_output_pin, status}, 4'h0);
        $display("test done: reset in mid-run");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
